//--- hdl/pmu_power_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module pmu_power_ctrl
#(
   parameter int       LP_OFF_CNT   = pmu_pkg::LP_OFF_CYC,
   parameter int       LP_IRQ_CNT   = pmu_pkg::LP_IRQ_CYC,
   parameter int       BTN_RST_CNT  = pmu_pkg::BTN_RST_CYC,
   parameter int       IRQ_WIN_CNT  = pmu_pkg::IRQ_WIN_CYC,
   parameter bit       HOLD_DEFAULT = 1'b0
)
(
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic                            hreadyout,
   output logic                            hresp,
   output logic [31:0]                     hrdata,
   input  wire logic                       main_supply_sense,
   input  wire logic                       power_button_n,
   input  wire logic                       power_hold_pin,
   input  wire logic [pmu_pkg::N_SRC-1:0]  irq_sources,
   input  wire logic                       thermal_shutdown_flag,
   input  wire logic                       sleep_pin,
   input  wire logic                       config_strap_two_gnd,
   input  wire logic [pmu_pkg::N_SEL-1:0]  resource_enable_pins,
   input  wire logic                       scaling_bus_clock_pin,
   input  wire logic                       scaling_bus_data_pin,
   output logic                            power_on_reset_out_n,
   output logic                            global_reset_out,
   output logic                            general_reset_pulse,
   output logic                            supplies_on,
   output logic                            sleep_mode_out,
   output logic                            interrupt_out_n,
   output logic [pmu_pkg::N_SEL-1:0]       converter_voltage_select,
   output logic [pmu_pkg::N_SEL-1:0]       ldo_voltage_select,
   output logic [pmu_pkg::N_RES-1:0]       request_resource_en
);
   import pmu_pkg::*;

   localparam logic [TIMER_W-1:0] LP_OFF_T  = TIMER_W'(LP_OFF_CNT);
   localparam logic [TIMER_W-1:0] LP_IRQ_T  = TIMER_W'(LP_IRQ_CNT);
   localparam logic [TIMER_W-1:0] BTN_RST_T = TIMER_W'(BTN_RST_CNT);
   localparam logic [TIMER_W-1:0] IRQ_WIN_T = TIMER_W'(IRQ_WIN_CNT);

   pmu_state_t          state_reg;
   pmu_state_t          state_next;
   logic [7:0]          device_control_reg_reg;
   logic [7:0]          device_control2_reg;
   logic [7:0]          irq_mask_reg;
   logic [7:0]          ldo_select_mapping_reg;
   logic [7:0]          power_request_map_a;
   logic [7:0]          power_request_map_b;
   logic [7:0]          clock_request_one_map;
   logic [7:0]          clock_request_two_map;
   logic                long_press_irq;
   logic                slept_by_sw_reg;
   logic                rd_busy_reg;
   logic                wr_pend_reg;
   logic [7:0]          addr_reg;
   logic [TIMER_W-1:0]  btn_cnt;
   logic [TIMER_W-1:0]  irq_cnt;
   logic                uvlo;
   logic                cfg_defaults;
   logic                irq_pending;
   logic                irq_window;
   logic                lp_long;
   logic                lp_block;
   logic                pwr_on_cond;
   logic                on_block;
   logic                off_req;
   logic                pin_sleep;
   logic                sleep_go;
   logic                turnoff_evt;
   logic                gen_reset;
   logic                powered;
   logic                accept;
   logic                wr_hit;
   logic [31:0]         rd_mux;

   // full reset from undervoltage, applied synchronously
   assign uvlo         = !main_supply_sense;
   assign cfg_defaults = (state_reg == ST_NO_SUPPLY) ||
                         (state_reg == ST_CONFIG);
   assign powered      = (state_reg == ST_ACTIVE) ||
                         (state_reg == ST_SLEEP);

   pmu_press_timer
   #(
      .W       (TIMER_W)
   )
   u_btn_timer
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (!power_button_n && !cfg_defaults),
      .count   (btn_cnt)
   );

   pmu_press_timer
   #(
      .W       (TIMER_W)
   )
   u_irq_timer
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .run     (irq_pending),
      .count   (irq_cnt)
   );

   assign irq_pending = |(irq_sources & ~irq_mask_reg) | long_press_irq;
   // window closes 5 s after the first unmasked flag
   assign irq_window  = irq_pending && (irq_cnt < IRQ_WIN_T);
   assign lp_long     = btn_cnt > LP_OFF_T;
   assign lp_block    = lp_long && (device_control2_reg[B_LP_OFF] ||
                                    device_control2_reg[B_LP_RST]);
   assign pwr_on_cond = !power_button_n || power_hold_pin ||
                        device_control_reg_reg[B_HOLD] || irq_window;
   assign on_block    = lp_block || thermal_shutdown_flag;
   assign off_req     = !pwr_on_cond || lp_block ||
                        device_control_reg_reg[B_DEVICE_OFF_BIT] ||
                        thermal_shutdown_flag;
   assign pin_sleep   = device_control2_reg[B_SLP_EN] &&
                        (sleep_pin == device_control2_reg[B_SLP_POL]);
   assign sleep_go    = config_strap_two_gnd && !irq_pending &&
                        (device_control_reg_reg[B_SW_SLEEP] || pin_sleep);
   // long press with reset enable counts as a turnoff event
   assign turnoff_evt = (btn_cnt == LP_OFF_T + 1'b1) &&
                        device_control2_reg[B_LP_RST];
   assign gen_reset   = (turnoff_evt && device_control_reg_reg[B_LOAD_OTP]) ||
                        ((btn_cnt == BTN_RST_T + 1'b1) &&
                         device_control2_reg[B_BTN_RST]);

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_NO_SUPPLY:
            state_next = ST_CONFIG;
         ST_CONFIG:
            state_next = ST_OFF;
         ST_OFF:
            if (pwr_on_cond && !on_block)
               state_next = ST_ACTIVE;
         ST_ACTIVE:
            if (device_control_reg_reg[B_LOAD_OTP])
               state_next = ST_CONFIG;
            else if (off_req)
               state_next = ST_OFF;
            else if (sleep_go)
               state_next = ST_SLEEP;
         ST_SLEEP:
            if (device_control_reg_reg[B_LOAD_OTP])
               state_next = ST_CONFIG;
            else if (off_req)
               state_next = ST_OFF;
            else if (!config_strap_two_gnd)
               state_next = ST_ACTIVE;
            else if (slept_by_sw_reg)
            begin
               // software sleep ignores the sleep pin on the way out
               if (irq_pending)
                  state_next = ST_ACTIVE;
            end
            else if (irq_pending || (!pin_sleep &&
                                     !device_control_reg_reg[B_SW_SLEEP]))
               state_next = ST_ACTIVE;
      endcase
      if (uvlo)
         state_next = ST_NO_SUPPLY;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         state_reg <= ST_NO_SUPPLY;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         slept_by_sw_reg <= 1'b0;
      else if (state_reg == ST_ACTIVE && state_next == ST_SLEEP)
         slept_by_sw_reg <= device_control_reg_reg[B_SW_SLEEP];
      else if (state_next != ST_SLEEP)
         slept_by_sw_reg <= 1'b0;
   end

   // reset, supply and sleep outputs follow the next state so they line up with state_reg
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         power_on_reset_out_n <= 1'b0;
         global_reset_out     <= 1'b1;
         supplies_on          <= 1'b0;
         sleep_mode_out       <= 1'b0;
         general_reset_pulse  <= 1'b0;
         interrupt_out_n      <= 1'b1;
      end
      else
      begin
         power_on_reset_out_n <= (state_next == ST_ACTIVE) ||
                                 (state_next == ST_SLEEP);
         global_reset_out     <= state_next == ST_NO_SUPPLY;
         supplies_on          <= state_next == ST_ACTIVE;
         sleep_mode_out       <= state_next == ST_SLEEP;
         general_reset_pulse  <= gen_reset && !uvlo;
         interrupt_out_n      <= !irq_pending;
      end
   end

   // ahb-lite slave: writes zero wait, reads one wait state
   assign accept    = hsel && hready && htrans[1];
   assign hreadyout = !rd_busy_reg;
   assign hresp     = 1'b0;
   assign wr_hit    = wr_pend_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         rd_busy_reg <= 1'b0;
         addr_reg    <= '0;
      end
      else
      begin
         wr_pend_reg <= accept && hwrite;
         rd_busy_reg <= accept && !hwrite;
         if (accept)
            addr_reg <= {haddr[7:2], 2'b00};
      end
   end

   always_comb
   begin
      rd_mux = '0;
      unique case (addr_reg)
         OFS_DEVICE_CONTROL_REG:  rd_mux[7:0] = device_control_reg_reg;
         OFS_DEVICE_CONTROL2_REG: rd_mux[7:0] = device_control2_reg;
         OFS_INT_STS:  rd_mux[1:0] = {irq_pending, long_press_irq};
         OFS_INT_MSK:  rd_mux[7:0] = irq_mask_reg;
         OFS_THERMAL:  rd_mux[0]   = thermal_shutdown_flag;
         OFS_STATE:    rd_mux[2:0] = state_reg;
         OFS_LDO_MAP:  rd_mux[7:0] = ldo_select_mapping_reg;
         OFS_PREQ_A:   rd_mux[7:0] = power_request_map_a;
         OFS_PREQ_B:   rd_mux[7:0] = power_request_map_b;
         OFS_CREQ1:    rd_mux[7:0] = clock_request_one_map;
         OFS_CREQ2:    rd_mux[7:0] = clock_request_two_map;
         default:      rd_mux      = '0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= '0;
      else if (rd_busy_reg)
         hrdata <= rd_mux;
   end

   // device control: only the hold bit reloads on general reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         device_control_reg_reg <= '0;
      else if (cfg_defaults || uvlo)
         device_control_reg_reg <= {7'h00, HOLD_DEFAULT};
      else if (gen_reset)
         device_control_reg_reg[B_HOLD] <= HOLD_DEFAULT;
      else
      begin
         if (wr_hit && addr_reg == OFS_DEVICE_CONTROL_REG)
            device_control_reg_reg <= hwdata[7:0];
         // device-off is a one-shot request
         if (state_reg == ST_OFF)
            device_control_reg_reg[B_DEVICE_OFF_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         device_control2_reg <= CTRL2_RST;
      else if (cfg_defaults || uvlo || gen_reset)
         device_control2_reg <= CTRL2_RST;
      else if (wr_hit && addr_reg == OFS_DEVICE_CONTROL2_REG)
         device_control2_reg <= hwdata[7:0];
   end

   // sticky long-press flag, write one to clear, set wins
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         long_press_irq <= 1'b0;
      else if (cfg_defaults || uvlo)
         long_press_irq <= 1'b0;
      else if (btn_cnt == LP_IRQ_T)
         long_press_irq <= 1'b1;
      else if (wr_hit && addr_reg == OFS_INT_STS && hwdata[B_LP_IRQ])
         long_press_irq <= 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_mask_reg           <= MASK_RST;
         ldo_select_mapping_reg <= LDO_MAP_RST;
         power_request_map_a    <= MAP_RST;
         power_request_map_b    <= MAP_RST;
         clock_request_one_map  <= MAP_RST;
         clock_request_two_map  <= MAP_RST;
      end
      else if (cfg_defaults || uvlo)
      begin
         irq_mask_reg           <= MASK_RST;
         ldo_select_mapping_reg <= LDO_MAP_RST;
         power_request_map_a    <= MAP_RST;
         power_request_map_b    <= MAP_RST;
         clock_request_one_map  <= MAP_RST;
         clock_request_two_map  <= MAP_RST;
      end
      else if (wr_hit)
      begin
         unique case (addr_reg)
            OFS_INT_MSK: irq_mask_reg           <= hwdata[7:0];
            OFS_LDO_MAP: ldo_select_mapping_reg <= hwdata[7:0];
            OFS_PREQ_A:  power_request_map_a    <= hwdata[7:0];
            OFS_PREQ_B:  power_request_map_b    <= hwdata[7:0];
            OFS_CREQ1:   clock_request_one_map  <= hwdata[7:0];
            OFS_CREQ2:   clock_request_two_map  <= hwdata[7:0];
            default:     ;
         endcase
      end
   end

   pmu_pin_mux u_pin_mux
   (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .strap_gnd   (config_strap_two_gnd),
      .powered     (powered),
      .enable_pins (resource_enable_pins),
      .clk_req_one (scaling_bus_clock_pin),
      .clk_req_two (scaling_bus_data_pin),
      .power_request_pin     (sleep_pin),
      .ldo_map     (ldo_select_mapping_reg),
      .preq_map_a  (power_request_map_a),
      .preq_map_b  (power_request_map_b),
      .creq1_map   (clock_request_one_map),
      .creq2_map   (clock_request_two_map),
      .conv_sel    (converter_voltage_select),
      .ldo_sel     (ldo_voltage_select),
      .req_en      (request_resource_en)
   );

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_uvlo;
      uvlo |=> state_reg == ST_NO_SUPPLY && global_reset_out &&
               !power_on_reset_out_n && !supplies_on;
   endproperty
   a_uvlo: assert property (p_uvlo)
      else $error("undervoltage did not force no-supply");

   property p_cfg_seq;
      state_reg == ST_NO_SUPPLY && !uvlo ##1 !uvlo |=>
         state_reg == ST_OFF && !power_on_reset_out_n;
   endproperty
   a_cfg_seq: assert property (p_cfg_seq)
      else $error("no-supply did not pass config into off");

   property p_rel;
      state_reg == ST_ACTIVE |-> power_on_reset_out_n && supplies_on;
   endproperty
   a_rel: assert property (p_rel)
      else $error("reset output not released in active");

   property p_pwr_on;
      state_reg == ST_OFF && !uvlo && pwr_on_cond && !on_block |=>
         state_reg == ST_ACTIVE;
   endproperty
   a_pwr_on: assert property (p_pwr_on)
      else $error("power-on condition ignored");

   property p_therm;
      state_reg == ST_OFF && thermal_shutdown_flag |=>
         state_reg != ST_ACTIVE;
   endproperty
   a_therm: assert property (p_therm)
      else $error("power-on during thermal shutdown");

   property p_off;
      state_reg == ST_ACTIVE && !uvlo && !device_control_reg_reg[B_LOAD_OTP] &&
         off_req |=> state_reg == ST_OFF && !power_on_reset_out_n;
   endproperty
   a_off: assert property (p_off)
      else $error("active did not power off");

   property p_no_sleep;
      !config_strap_two_gnd |=> state_reg != ST_SLEEP;
   endproperty
   a_no_sleep: assert property (p_no_sleep)
      else $error("sleep entered with strap high");

   property p_lp_irq;
      btn_cnt == LP_IRQ_T && !cfg_defaults && !uvlo |=> long_press_irq;
   endproperty
   a_lp_irq: assert property (p_lp_irq)
      else $error("long-press flag not raised at 4 s");

   property p_win;
      state_reg == ST_OFF && irq_cnt >= IRQ_WIN_T && power_button_n &&
         !power_hold_pin && !device_control_reg_reg[B_HOLD] |=> state_reg != ST_ACTIVE;
   endproperty
   a_win: assert property (p_win)
      else $error("interrupt window outlived 5 s");
endmodule
`default_nettype wire

//--- hdl/pmu_pkg.sv
package pmu_pkg;
   localparam int          CLK_HZ         = 25_000_000;
   localparam int          CLK_KHZ        = CLK_HZ / 1000;
   // press and window times in milliseconds
   localparam int          LP_OFF_MS      = 5000;
   localparam int          LP_IRQ_MS      = 4000;
   localparam int          BTN_RST_MS     = 100;
   localparam int          IRQ_WIN_MS     = 5000;
   localparam int          LP_OFF_CYC     = LP_OFF_MS * CLK_KHZ;
   localparam int          LP_IRQ_CYC     = LP_IRQ_MS * CLK_KHZ;
   localparam int          BTN_RST_CYC    = BTN_RST_MS * CLK_KHZ;
   localparam int          IRQ_WIN_CYC    = IRQ_WIN_MS * CLK_KHZ;
   localparam int          TIMER_W        = 27;
   localparam int          N_SRC          = 8;
   localparam int          N_RES          = 8;
   localparam int          N_SEL          = 4;
   // register byte offsets
   localparam logic [7:0]  OFS_DEVICE_CONTROL_REG    = 8'h00;
   localparam logic [7:0]  OFS_DEVICE_CONTROL2_REG   = 8'h04;
   localparam logic [7:0]  OFS_INT_STS    = 8'h08;
   localparam logic [7:0]  OFS_INT_MSK    = 8'h0c;
   localparam logic [7:0]  OFS_THERMAL    = 8'h10;
   localparam logic [7:0]  OFS_STATE      = 8'h14;
   localparam logic [7:0]  OFS_LDO_MAP    = 8'h18;
   localparam logic [7:0]  OFS_PREQ_A     = 8'h1c;
   localparam logic [7:0]  OFS_PREQ_B     = 8'h20;
   localparam logic [7:0]  OFS_CREQ1      = 8'h24;
   localparam logic [7:0]  OFS_CREQ2      = 8'h28;
   // device_control_reg fields
   localparam int          B_HOLD         = 0;
   localparam int          B_DEVICE_OFF_BIT      = 1;
   localparam int          B_SW_SLEEP     = 2;
   localparam int          B_LOAD_OTP     = 6;
   // device_control2_reg fields
   localparam int          B_LP_OFF       = 0;
   localparam int          B_LP_RST       = 1;
   localparam int          B_SLP_EN       = 2;
   localparam int          B_SLP_POL      = 3;
   localparam int          B_BTN_RST      = 4;
   // interrupt_status_reg fields
   localparam int          B_LP_IRQ       = 0;
   localparam int          B_PENDING      = 1;
   localparam logic [7:0]  CTRL2_RST      = 8'h01;
   localparam logic [7:0]  MASK_RST       = 8'h00;
   localparam logic [7:0]  LDO_MAP_RST    = 8'he4;
   localparam logic [7:0]  MAP_RST        = 8'h00;
   typedef enum logic [2:0] {
      ST_NO_SUPPLY,
      ST_CONFIG,
      ST_OFF,
      ST_ACTIVE,
      ST_SLEEP
   } pmu_state_t;
endpackage

//--- hdl/pmu_press_timer.sv
`timescale 1ns/100ps
`default_nettype none
// saturating count of cycles that run has been held high
module pmu_press_timer
#(
   parameter int W = 27
)
(
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         run,
   output logic [W-1:0]      count
);
   logic [W-1:0] count_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         count_reg <= '0;
      else if (!run)
         count_reg <= '0;
      else if (count_reg != {W{1'b1}})
         count_reg <= count_reg + 1'b1;
   end

   assign count = count_reg;
endmodule
`default_nettype wire

//--- hdl/pmu_pin_mux.sv
`timescale 1ns/100ps
`default_nettype none
// strap-grounded remapping of enable and request pins
module pmu_pin_mux
   import pmu_pkg::*;
(
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               strap_gnd,
   input  wire logic               powered,
   input  wire logic [N_SEL-1:0]   enable_pins,
   input  wire logic               clk_req_one,
   input  wire logic               clk_req_two,
   input  wire logic               power_request_pin,
   input  wire logic [7:0]         ldo_map,
   input  wire logic [N_RES-1:0]   preq_map_a,
   input  wire logic [N_RES-1:0]   preq_map_b,
   input  wire logic [N_RES-1:0]   creq1_map,
   input  wire logic [N_RES-1:0]   creq2_map,
   output logic [N_SEL-1:0]        conv_sel,
   output logic [N_SEL-1:0]        ldo_sel,
   output logic [N_RES-1:0]        req_en
);
   logic [N_SEL-1:0] ldo_sel_next;
   logic [N_RES-1:0] req_en_next;

   genvar i;
   generate
      for (i = 0; i < N_SEL; i++)
      begin : g_ldo
         // each ldo follows whichever select pin its field names
         assign ldo_sel_next[i] = strap_gnd &
                                  enable_pins[ldo_map[2*i +: 2]];
      end
   endgenerate

   assign req_en_next = {N_RES{strap_gnd & powered}} &
                        (({N_RES{power_request_pin}} & (preq_map_a | preq_map_b)) |
                         ({N_RES{clk_req_one}} & creq1_map) |
                         ({N_RES{clk_req_two}} & creq2_map));

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         conv_sel <= '0;
         ldo_sel  <= '0;
         req_en   <= '0;
      end
      else
      begin
         conv_sel <= strap_gnd ? enable_pins : '0;
         ldo_sel  <= ldo_sel_next;
         req_en   <= req_en_next;
      end
   end
endmodule
`default_nettype wire

//--- verification/pmu_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side: holds power up and presses the button on request
module pmu_host_model
(
   input  wire logic hclk,
   input  wire logic want_on,
   input  wire logic press,
   output logic      power_button_n,
   output logic      power_hold_pin
);
   initial
   begin
      power_button_n = 1'b1;
      power_hold_pin = 1'b0;
   end
   always @(posedge hclk)
   begin
      power_hold_pin <= want_on;
      power_button_n <= ~press;
   end
endmodule
`default_nettype wire

//--- verification/pmu_power_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pmu_power_ctrl_tb;
   import pmu_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, th = 0, slp = 0;
   logic strap = 0, on = 0, press = 0, btn_n, hold, rdy, resp;
   logic sup_ok = 1, ck1 = 0, ck2 = 0, glob, grp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, v;
   logic [1:0]  htrans = 0;
   logic [3:0]  pins = 0, csel, lsel;
   logic [7:0]  irq = 0, req;
   logic        por_n, sup, sm, int_n;
   int          fails = 0, n_compared = 0, seed = 32'haeb9e003, npulse;
   always #20 hclk = ~hclk;
   pmu_host_model i_host (.hclk(hclk), .want_on(on), .press(press),
      .power_button_n(btn_n), .power_hold_pin(hold));
   pmu_power_ctrl #(.LP_OFF_CNT(50), .LP_IRQ_CNT(40), .BTN_RST_CNT(10),
      .IRQ_WIN_CNT(50)) i_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy),
      .hresp(resp), .hrdata(hrdata), .main_supply_sense(sup_ok),
      .power_button_n(btn_n), .power_hold_pin(hold), .irq_sources(irq),
      .thermal_shutdown_flag(th), .sleep_pin(slp),
      .config_strap_two_gnd(strap), .resource_enable_pins(pins),
      .scaling_bus_clock_pin(ck1), .scaling_bus_data_pin(ck2),
      .power_on_reset_out_n(por_n), .global_reset_out(glob),
      .general_reset_pulse(grp), .supplies_on(sup), .sleep_mode_out(sm),
      .interrupt_out_n(int_n), .converter_voltage_select(csel),
      .ldo_voltage_select(lsel), .request_resource_en(req));
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, s);
      n_compared++;
      if (s !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // ldo i follows the select pin named by its two-bit map field
   function automatic logic [3:0] ldo_exp(input logic [7:0] m,
                                          input logic [3:0] p);
      for (int i = 0; i < 4; i++)
         ldo_exp[i] = p[m[2*i +: 2]];
   endfunction
   // wait for hready at an edge; a hang ends the run
   task automatic wait_rdy();
      int k;
      k = 0;
      @(posedge hclk);
      while (rdy !== 1'b1)
      begin
         if (++k > 20)
         begin
            fails++;
            summarize();
         end
         @(posedge hclk);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic go(input int n);
      repeat (n) @(posedge hclk);
   endtask
   initial
   begin
      go(6);
      hresetn <= 1'b1;
      go(3);
      chk("por_n off", 0, por_n);
      chk("supplies off", 0, sup);
      bus(0, OFS_STATE, 0);
      chk("state", 2, rd);
      chk("hresp", 0, resp);
      bus(0, OFS_DEVICE_CONTROL2_REG, 0);
      chk("ctrl2", 32'h1, rd);
      bus(0, OFS_LDO_MAP, 0);
      chk("ldo map", 32'he4, rd);
      bus(0, 8'h40, 0);
      chk("unmapped", 0, rd);
      strap <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         v = $random(seed);
         pins <= (i == 0) ? 4'hf : v[3:0];
         go(3);
         chk("conv sel", pins, csel);
      end
      on <= 1'b1;
      go(3);
      chk("supplies", 1, sup);
      chk("por_n", 1, por_n);
      v = $random(seed);
      bus(1, OFS_LDO_MAP, v);
      bus(1, OFS_PREQ_A, v >> 8);
      bus(1, OFS_CREQ1, v >> 16);
      bus(1, OFS_CREQ2, v >> 24);
      slp <= 1'b1;
      ck1 <= 1'b1;
      ck2 <= 1'b1;
      go(3);
      chk("ldo sel", ldo_exp(v[7:0], pins), lsel);
      chk("req en", v[15:8] | v[23:16] | v[31:24], req);
      slp <= 1'b0;
      ck1 <= 1'b0;
      ck2 <= 1'b0;
      bus(1, OFS_DEVICE_CONTROL_REG, 32'h2);
      go(2);
      chk("device_off_bit", 0, sup);
      go(3);
      chk("device_off_bit once", 1, sup);
      bus(1, OFS_DEVICE_CONTROL_REG, 32'h40);
      go(2);
      chk("reload por_n", 0, por_n);
      bus(0, OFS_LDO_MAP, 0);
      chk("reload map", 32'he4, rd);
      // strap grounded, no sw sleep used with strap high
      bus(1, OFS_DEVICE_CONTROL2_REG, 32'h0d);
      slp <= 1'b1;
      go(3);
      chk("sleep", 1, sm);
      slp <= 1'b0;
      go(3);
      chk("awake", 0, sm);
      bus(1, OFS_DEVICE_CONTROL_REG, 32'h4);
      go(3);
      chk("sw sleep", 1, sm);
      irq <= 8'h01;
      go(3);
      chk("irq wake", 0, sm);
      bus(1, OFS_DEVICE_CONTROL_REG, 32'h0);
      irq <= 8'h00;
      strap <= 1'b0;
      slp <= 1'b1;
      go(3);
      chk("no sleep", 0, sm);
      slp <= 1'b0;
      th <= 1'b1;
      go(3);
      chk("thermal off", 0, sup);
      go(3);
      chk("thermal block", 0, sup);
      th <= 1'b0;
      on <= 1'b0;
      go(3);
      press <= 1'b1;
      go(30);
      chk("irq early", 1, int_n);
      chk("press on", 1, sup);
      go(18);
      chk("irq late", 0, int_n);
      go(14);
      chk("long press off", 0, sup);
      press <= 1'b0;
      go(6);
      chk("irq window on", 1, sup);
      go(40);
      chk("irq window shut", 0, sup);
      bus(1, OFS_INT_STS, 32'h1);
      go(3);
      chk("irq cleared", 1, int_n);
      bus(1, OFS_INT_MSK, 32'hff);
      irq <= 8'h80;
      go(4);
      chk("masked irq", 0, sup);
      chk("masked int_n", 1, int_n);
      irq <= 8'h00;
      bus(1, OFS_DEVICE_CONTROL2_REG, 32'h10);
      press <= 1'b1;
      npulse = 0;
      repeat (20)
      begin
         @(posedge hclk);
         npulse += grp;
      end
      chk("gen reset pulses", 1, npulse);
      press <= 1'b0;
      bus(0, OFS_DEVICE_CONTROL2_REG, 0);
      chk("ctrl2 reload", 32'h1, rd);
      sup_ok <= 1'b0;
      go(3);
      chk("global reset", 1, glob);
      chk("por_n uvlo", 0, por_n);
      sup_ok <= 1'b1;
      go(3);
      chk("global reset off", 0, glob);
      bus(0, OFS_INT_MSK, 0);
      chk("mask default", 0, rd);
      summarize();
   end
endmodule
`default_nettype wire
